// ### hw/ioff_consts.svh
// Constants for the overlay, format and filter core
`ifndef IOFF_CONSTS_SVH
`define IOFF_CONSTS_SVH
`define IOFF_ALPHA_FULL    8'h80
`define IOFF_ALPHA_SCALE   9'h080
`define IOFF_BLEND_ROUND   16'h0040
`define IOFF_BLEND_SHIFT   7
`define IOFF_COEF_W        10
`define IOFF_COEF_SHIFT    8
`define IOFF_FILT_ROUND    22'h000080
`define IOFF_NTAPS         5
`define IOFF_NPHASES       32
`define IOFF_WORD_BYTES    4'h4
`endif

// ### hw/ioff_pkg.sv
// Types shared by the overlay, format and filter core
package ioff_pkg;
    typedef enum logic [1:0] {IOFF_OP_FORMAT, IOFF_OP_HFILT, IOFF_OP_VFILT} ioff_op_t;
    typedef enum logic [1:0] {
        IOFF_LAY_422_COSITED, IOFF_LAY_422_INTER, IOFF_LAY_420_INTER, IOFF_LAY_411_COSITED
    } ioff_layout_t;
    typedef enum logic [1:0] {
        IOFF_OV_RGB_888_WITH_BLEND_BYTE, IOFF_OV_RGB_555_WITH_BLEND_BIT,
        IOFF_OV_YUV_422_WITH_BLEND_BITS
    } ioff_ovfmt_t;
    typedef enum logic [2:0] {
        IOFF_OUT_RGB_8BIT_RED2_GREEN3_BLUE3, IOFF_OUT_RGB_8BIT_RED3_GREEN3_BLUE2,
        IOFF_OUT_RGB_555_WITH_BLEND_BIT, IOFF_OUT_RGB_565_OUTPUT,
        IOFF_OUT_RGB_888_WITH_BLEND_BYTE, IOFF_OUT_RGB_888_PACKED_OUTPUT, IOFF_OUT_YUV_422
    } ioff_outfmt_t;
endpackage : ioff_pkg

// ### hw/ioff_core.sv
// Overlay unpack, alpha blend, output packing and 5-tap mirrored filter
//
// Summary of operation
// [RQ1] Main image fetched planar: separate Y, U, V table indices are produced; the code gives o_y_idx and one o_c_idx shared by U and V.
// [RQ2] 4:2:2 co-sited: chroma coincides with luma on every second pixel.
// [RQ3] 4:2:0 interspersed: chroma lies midway between luma, every second pixel.
// [RQ4] 4:1:1 co-sited: chroma coincides with luma on every fourth pixel.
// [RQ5] 32-bit RGB with alpha: alpha, red, green, blue bytes, high to low.
// [RQ6] 15-bit RGB: two pixels per word, alpha bit on top, pixel 0 low.
// [RQ7] YUV overlay: Y1, V7..1+alpha1, Y0, U7..1+alpha0, high to low.
// [RQ8] Software pairs overlay and output colour types; no overlay conversion.
// [RQ9] One-bit alpha selects high or low blend code, latched at job start.
// [RQ10] Blend codes: 00h image, 20h/40h/60h quarters, 80h and above overlay.
// [RQ11] Between points, overlay weight is code/128, rounded.
// [RQ12] 2-3-3 output: four bytes per word, pixel 0 lowest.
// [RQ13] 3-3-2 output: four bytes per word, pixel 0 lowest.
// [RQ14] 5-6-5 output: two pixels per word, pixel 0 low half.
// [RQ15] Packed 24-bit output: four pixels in three words, byte stream.
// [RQ16] IOFF_OUT_YUV_422 output: Y1 V0 Y0 U0, two pixels per word.
// [RQ17] Horizontal pass filters one component with five taps.
// [RQ18] Vertical pass filters one component with five taps.
// [RQ19] Output is coefficient-weighted sum of centre and two neighbours each side.
// [RQ20] Coefficients chosen by output phase relative to centre sample.
// [RQ21] Line start mirrors: 2,1,0,1,2 then 1,0,1,2,3.
// [RQ22] Line end mirrors: N-3..N,N-1 then N-2,N-1,N,N-1,N-2.
// [RQ23] Centre beyond last input repeats the previous output sample.
`timescale 1ns/1ps
`default_nettype none
`include "ioff_consts.svh"
module ioff_core import ioff_pkg::*; #(
    parameter int LINE_DEPTH = 1024
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_job_start,
    input  wire ioff_op_t               i_op,
    input  wire ioff_layout_t           i_layout,
    input  wire ioff_ovfmt_t            i_ovl_fmt,
    input  wire ioff_outfmt_t           i_out_fmt,
    input  wire logic [7:0]             i_alpha_hi,
    input  wire logic [7:0]             i_alpha_lo,
    input  wire logic                   i_pix_valid,
    output logic                        o_pix_ready,
    input  wire logic                   i_pix_last,
    input  wire logic [7:0]             i_img_c0,
    input  wire logic [7:0]             i_img_c1,
    input  wire logic [7:0]             i_img_c2,
    input  wire logic [31:0]            i_ovl_word,
    input  wire logic                   i_ovl_en,
    output logic [15:0]                 o_y_idx,
    output logic [15:0]                 o_c_idx,
    output logic                        o_c_sited,
    input  wire logic                   i_smp_valid,
    input  wire logic                   i_smp_last,
    input  wire logic [7:0]             i_smp,
    input  wire logic                   i_req_valid,
    output logic                        o_req_ready,
    input  wire logic                   i_req_last,
    input  wire logic [$clog2(LINE_DEPTH):0] i_req_center,
    input  wire logic [4:0]             i_req_phase,
    input  wire logic                   i_coef_we,
    input  wire logic [4:0]             i_coef_phase,
    input  wire logic [2:0]             i_coef_tap,
    input  wire logic [`IOFF_COEF_W-1:0] i_coef_data,
    output logic [$clog2(LINE_DEPTH)-1:0] o_last_idx,
    output logic [31:0]                 o_word,
    output logic                        o_word_valid,
    input  wire logic                   i_word_ready
);
    localparam int IW = $clog2(LINE_DEPTH);

    // ----------------------------------------------------------------
    // Job settings
    // ----------------------------------------------------------------
    ioff_op_t     op_q, op_d;
    ioff_layout_t lay_q, lay_d;
    ioff_ovfmt_t  ovf_q, ovf_d;
    ioff_outfmt_t outf_q, outf_d;
    logic [7:0]   ahi_q, ahi_d, alo_q, alo_d;

    always_comb begin
        op_d = op_q; lay_d = lay_q; ovf_d = ovf_q; outf_d = outf_q;
        ahi_d = ahi_q; alo_d = alo_q;
        if (i_job_start) begin
            op_d = i_op; lay_d = i_layout; ovf_d = i_ovl_fmt; outf_d = i_out_fmt;
            ahi_d = i_alpha_hi; // RQ9
            alo_d = i_alpha_lo; // RQ9
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            op_q <= IOFF_OP_FORMAT; lay_q <= IOFF_LAY_422_COSITED;
            ovf_q <= IOFF_OV_RGB_888_WITH_BLEND_BYTE;
            outf_q <= IOFF_OUT_RGB_888_WITH_BLEND_BYTE;
            ahi_q <= 8'h00; alo_q <= 8'h00;
        end else begin
            op_q <= op_d; lay_q <= lay_d; ovf_q <= ovf_d; outf_q <= outf_d;
            ahi_q <= ahi_d; alo_q <= alo_d;
        end
    end

    // ----------------------------------------------------------------
    // Line memory and coefficient table
    // ----------------------------------------------------------------
    logic [7:0]              line_mem [LINE_DEPTH];
    logic [`IOFF_COEF_W-1:0] coef_mem [`IOFF_NPHASES][`IOFF_NTAPS];
    logic [IW-1:0]           wr_q, wr_d, last_q, last_d;

    always_comb begin
        wr_d = wr_q;
        last_d = last_q;
        if (i_job_start) begin
            wr_d = '0;
        end else if (i_smp_valid) begin
            wr_d = wr_q + 1'b1;
            if (i_smp_last) begin
                last_d = wr_q;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_q <= '0;
            last_q <= '0;
        end else begin
            wr_q <= wr_d;
            last_q <= last_d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_smp_valid && !i_job_start) begin
            line_mem[wr_q] <= i_smp;
        end
        if (i_coef_we) begin
            coef_mem[i_coef_phase][i_coef_tap] <= i_coef_data; // RQ20
        end
    end

    assign o_last_idx = last_q;

    // ----------------------------------------------------------------
    // Five-tap filter with edge mirroring
    // ----------------------------------------------------------------
    logic signed [21:0] fsum;
    logic        [7:0]  fout;
    logic signed [IW+1:0] tap_j [`IOFF_NTAPS];

    genvar gk;
    generate
        for (gk = 0; gk < `IOFF_NTAPS; gk++) begin : g_tap
            logic signed [IW+1:0] raw;
            logic signed [IW+1:0] nl;
            assign nl  = $signed({2'b00, last_q});
            assign raw = $signed({1'b0, i_req_center}) + (IW+2)'(gk - 2);
            always_comb begin
                tap_j[gk] = raw;
                if (raw < 0) begin
                    tap_j[gk] = -raw; // RQ21
                end else if (raw > nl) begin
                    tap_j[gk] = (IW+2)'(2 * nl - raw); // RQ22
                end
            end
        end
    endgenerate

    always_comb begin
        logic signed [21:0] acc;
        acc = '0;
        for (int k = 0; k < `IOFF_NTAPS; k++) begin // RQ19
            acc = acc + 22'($signed(coef_mem[i_req_phase][k])
                  * $signed({1'b0, line_mem[tap_j[k][IW-1:0]]})); // RQ17 RQ18 RQ20
        end
        // Signed rounding so a negative sum clamps to zero, not to full scale
        fsum = (acc + $signed(`IOFF_FILT_ROUND)) >>> `IOFF_COEF_SHIFT;
        if (fsum < 0) begin
            fout = 8'h00;
        end else if (fsum > 22'sd255) begin
            fout = 8'hff;
        end else begin
            fout = fsum[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Overlay unpack and blend
    // ----------------------------------------------------------------
    function automatic logic [7:0] blend(input logic [7:0] img, input logic [7:0] ovl,
                                         input logic [7:0] code);
        logic [8:0]  w;
        logic [15:0] s;
        w = (code >= `IOFF_ALPHA_FULL) ? `IOFF_ALPHA_SCALE : {2'b00, code[6:0]}; // RQ10
        s = 16'(ovl * w) + 16'(img * (`IOFF_ALPHA_SCALE - w)) + `IOFF_BLEND_ROUND; // RQ11
        return s[14:7];
    endfunction : blend

    logic [15:0] x_q, x_d;
    logic [7:0]  ov0, ov1, ov2, acode, b0, b1, b2, vsave_q, vsave_d, prev_q, prev_d;
    logic [15:0] half;
    logic        abit;

    always_comb begin
        half = x_q[0] ? i_ovl_word[31:16] : i_ovl_word[15:0]; // RQ6
        ov0 = i_ovl_word[23:16]; // RQ5
        ov1 = i_ovl_word[15:8];
        ov2 = i_ovl_word[7:0];
        abit = 1'b0;
        acode = i_ovl_word[31:24];
        case (ovf_q)
            IOFF_OV_RGB_555_WITH_BLEND_BIT: begin
                abit = half[15];
                ov0 = {half[14:10], half[14:12]};
                ov1 = {half[9:5], half[9:7]};
                ov2 = {half[4:0], half[4:2]};
                acode = abit ? ahi_q : alo_q; // RQ9
            end
            IOFF_OV_YUV_422_WITH_BLEND_BITS: begin
                abit = x_q[0] ? i_ovl_word[16] : i_ovl_word[0]; // RQ7
                ov0 = x_q[0] ? i_ovl_word[31:24] : i_ovl_word[15:8];
                ov1 = {i_ovl_word[7:1], 1'b0};
                ov2 = {i_ovl_word[23:17], 1'b0};
                acode = abit ? ahi_q : alo_q; // RQ9
            end
            default: ;
        endcase
        // No conversion of overlay colour type happens here
        if (!i_ovl_en) begin
            acode = 8'h00; // RQ8
        end
        b0 = blend(i_img_c0, ov0, acode);
        b1 = blend(i_img_c1, ov1, acode);
        b2 = blend(i_img_c2, ov2, acode);
    end

    // Planar table indices; interspersed layouts are never co-sited
    always_comb begin
        o_y_idx = x_q; // RQ1
        o_c_idx = {1'b0, x_q[15:1]}; // RQ2 RQ3
        o_c_sited = 1'b0; // RQ3
        case (lay_q)
            IOFF_LAY_422_COSITED: o_c_sited = ~x_q[0]; // RQ2
            IOFF_LAY_411_COSITED: begin
                o_c_idx = {2'b00, x_q[15:2]}; // RQ4
                o_c_sited = (x_q[1:0] == 2'b00); // RQ4
            end
            default: ;
        endcase
    end

    // ----------------------------------------------------------------
    // Byte packer feeding a two-entry output buffer
    // ----------------------------------------------------------------
    logic [55:0] acc_q, acc_d, ext;
    logic [2:0]  cnt_q, cnt_d;
    logic [3:0]  cntn;
    logic [31:0] nb;
    logic [2:0]  nn;
    logic        take, flush;
    logic [31:0] buf_q [2];
    logic [31:0] buf_d [2];
    logic [1:0]  fill_q, fill_d;
    logic        push_a, push_b;
    logic [31:0] wa, wb;

    // Room for two words before a line end, since flush may emit a second word
    assign o_pix_ready = (op_q == IOFF_OP_FORMAT) && (fill_q == 2'd0 || (!i_pix_last
                         && fill_q == 2'd1));
    assign o_req_ready = (op_q != IOFF_OP_FORMAT) && (fill_q == 2'd0 || (!i_req_last
                         && fill_q == 2'd1));

    always_comb begin
        nb = 32'h0; nn = 3'd0; take = 1'b0; flush = 1'b0;
        x_d = x_q; vsave_d = vsave_q; prev_d = prev_q;
        if (op_q == IOFF_OP_FORMAT) begin
            take = i_pix_valid && o_pix_ready;
            flush = i_pix_last;
            case (outf_q)
                IOFF_OUT_RGB_8BIT_RED2_GREEN3_BLUE3: begin
                    nb = {24'h0, b0[7:6], b1[7:5], b2[7:5]}; nn = 3'd1; // RQ12
                end
                IOFF_OUT_RGB_8BIT_RED3_GREEN3_BLUE2: begin
                    nb = {24'h0, b0[7:5], b1[7:5], b2[7:6]}; nn = 3'd1; // RQ13
                end
                IOFF_OUT_RGB_555_WITH_BLEND_BIT: begin
                    nb = {16'h0, abit, b0[7:3], b1[7:3], b2[7:3]}; nn = 3'd2; // RQ6
                end
                IOFF_OUT_RGB_565_OUTPUT: begin
                    nb = {16'h0, b0[7:3], b1[7:2], b2[7:3]}; nn = 3'd2; // RQ14
                end
                IOFF_OUT_RGB_888_PACKED_OUTPUT: begin
                    nb = {8'h0, b0, b1, b2}; nn = 3'd3; // RQ15
                end
                IOFF_OUT_YUV_422: begin
                    nb = x_q[0] ? {16'h0, b0, vsave_q} : {16'h0, b0, b1}; // RQ16
                    nn = 3'd2;
                end
                default: begin
                    nb = {acode, b0, b1, b2}; nn = 3'd4; // RQ5
                end
            endcase
            if (take) begin
                x_d = i_pix_last ? 16'h0 : x_q + 16'h1;
                vsave_d = b2;
            end
        end else begin
            take = i_req_valid && o_req_ready;
            flush = i_req_last;
            // Past the mirrored range: repeat last output
            nb = {24'h0, (i_req_center > {1'b0, last_q}) ? prev_q : fout}; // RQ23
            nn = 3'd1;
            if (take) begin
                prev_d = nb[7:0];
            end
        end
        if (i_job_start) begin
            x_d = 16'h0;
        end
    end

    always_comb begin
        ext = acc_q | (56'(nb) << (cnt_q * 8));
        cntn = {1'b0, cnt_q} + {1'b0, nn};
        acc_d = acc_q; cnt_d = cnt_q;
        push_a = 1'b0; push_b = 1'b0;
        wa = ext[31:0]; wb = {8'h00, ext[55:32]};
        if (take) begin
            acc_d = ext; cnt_d = cntn[2:0];
            if (cntn >= `IOFF_WORD_BYTES) begin
                push_a = 1'b1;
                acc_d = ext >> 32;
                cnt_d = 3'(cntn - `IOFF_WORD_BYTES);
                push_b = flush && (cntn > `IOFF_WORD_BYTES);
            end else begin
                push_a = flush && (cntn != 4'h0);
            end
            if (flush) begin
                acc_d = '0; cnt_d = 3'd0;
            end
        end
        if (i_job_start) begin
            acc_d = '0; cnt_d = 3'd0;
        end
    end

    assign o_word = buf_q[0];
    assign o_word_valid = (fill_q != 2'd0);

    always_comb begin
        logic [1:0] c;
        c = fill_q;
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        if (o_word_valid && i_word_ready) begin
            buf_d[0] = buf_q[1];
            c = c - 2'd1;
        end
        if (push_a) begin
            buf_d[c[0]] = wa;
            c = c + 2'd1;
        end
        if (push_b) begin
            buf_d[c[0]] = wb;
            c = c + 2'd1;
        end
        fill_d = c;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            x_q <= 16'h0; vsave_q <= 8'h00; prev_q <= 8'h00;
            acc_q <= '0; cnt_q <= 3'd0; fill_q <= 2'd0;
            buf_q[0] <= 32'h0; buf_q[1] <= 32'h0;
        end else begin
            x_q <= x_d; vsave_q <= vsave_d; prev_q <= prev_d;
            acc_q <= acc_d; cnt_q <= cnt_d; fill_q <= fill_d;
            buf_q[0] <= buf_d[0]; buf_q[1] <= buf_d[1];
        end
    end
endmodule : ioff_core
`default_nettype wire

// ### verification/ioff_core_asserts.sv
// Port checker for the overlay, format and filter core
`timescale 1ns/1ps
`default_nettype none
module ioff_core_asserts import ioff_pkg::*; #(
    parameter int LINE_DEPTH = 1024
) (
    input wire logic                          i_mclk,
    input wire logic                          i_rstn,
    input wire logic                          i_job_start,
    input wire ioff_op_t                      i_op,
    input wire ioff_layout_t                  i_layout,
    input wire logic                          i_pix_valid,
    input wire logic                          o_pix_ready,
    input wire logic                          i_pix_last,
    input wire logic [15:0]                   o_y_idx,
    input wire logic [15:0]                   o_c_idx,
    input wire logic                          o_c_sited,
    input wire logic                          i_smp_valid,
    input wire logic                          i_smp_last,
    input wire logic                          i_req_valid,
    input wire logic                          o_req_ready,
    input wire logic                          i_req_last,
    input wire logic [$clog2(LINE_DEPTH)-1:0] o_last_idx,
    input wire logic [31:0]                   o_word,
    input wire logic                          o_word_valid,
    input wire logic                          i_word_ready
);
    // ----------
    // Job settings shadowed here, the core latches them out of sight
    // ----------
    ioff_op_t                      op_q, op_d;
    ioff_layout_t                  lay_q, lay_d;
    logic                          go_q, go_d;
    logic [$clog2(LINE_DEPTH)-1:0] wi_q, wi_d;
    wire logic                     take = i_pix_valid && o_pix_ready;
    always_comb begin
        op_d  = i_job_start ? i_op : op_q;
        lay_d = i_job_start ? i_layout : lay_q;
        go_d  = go_q | i_job_start;
        wi_d  = i_job_start ? '0 : (i_smp_valid ? wi_q + 1'b1 : wi_q);
    end
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            op_q  <= IOFF_OP_FORMAT;
            lay_q <= IOFF_LAY_422_COSITED;
            go_q  <= 1'b0;
            wi_q  <= '0;
        end else begin
            op_q  <= op_d;
            lay_q <= lay_d;
            go_q  <= go_d;
            wi_q  <= wi_d;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    a_word_hold: assert property (o_word_valid && !i_word_ready
        |=> o_word_valid && $stable(o_word))
        else $error("stalled word changed or vanished");
    a_pix_flush: assert property (take && i_pix_last |=> o_word_valid)
        else $error("no word after last pixel");
    a_req_flush: assert property (i_req_valid && o_req_ready && i_req_last
        |=> o_word_valid)
        else $error("no word after last filter request");
    a_fmt_no_req: assert property (go_q && op_q == IOFF_OP_FORMAT |-> !o_req_ready)
        else $error("filter request accepted in format job");
    a_filt_no_pix: assert property (go_q && op_q != IOFF_OP_FORMAT |-> !o_pix_ready)
        else $error("pixel accepted in filter job");
    a_idx_clear: assert property (i_job_start |=> o_y_idx == 16'h0000)
        else $error("luma index not cleared at job start");
    a_idx_step: assert property (take && !i_pix_last && !i_job_start
        |=> o_y_idx == $past(o_y_idx) + 16'h0001)
        else $error("luma index did not advance");
    a_cosite_two: assert property (go_q && lay_q == IOFF_LAY_422_COSITED
        |-> o_c_sited == !o_y_idx[0] && o_c_idx == (o_y_idx >> 1))
        else $error("co-sited 4:2:2 chroma placement wrong");
    a_inter_mid: assert property (go_q && lay_q inside {IOFF_LAY_422_INTER, IOFF_LAY_420_INTER}
        |-> !o_c_sited && o_c_idx == (o_y_idx >> 1))
        else $error("interspersed chroma placement wrong");
    a_cosite_four: assert property (go_q && lay_q == IOFF_LAY_411_COSITED
        |-> o_c_sited == (o_y_idx[1:0] == 2'h0) && o_c_idx == (o_y_idx >> 2))
        else $error("co-sited 4:1:1 chroma placement wrong");
    a_last_index: assert property (i_smp_valid && i_smp_last && !i_job_start
        |=> o_last_idx == $past(wi_q))
        else $error("last sample index wrong");
endmodule : ioff_core_asserts
bind ioff_core ioff_core_asserts #(.LINE_DEPTH(LINE_DEPTH)) ioff_core_asserts_i (.i_mclk, .i_rstn,
    .i_job_start, .i_op, .i_layout, .i_pix_valid, .o_pix_ready, .i_pix_last, .o_y_idx, .o_c_idx,
    .o_c_sited, .i_smp_valid, .i_smp_last, .i_req_valid, .o_req_ready, .i_req_last, .o_last_idx,
    .o_word, .o_word_valid, .i_word_ready);
`default_nettype wire

// ### verification/ioff_sink.sv
// Word sink standing in for the memory highway and bus interface
`timescale 1ns/1ps
`default_nettype none
module ioff_sink (
    input  wire logic        i_mclk,
    input  wire logic        i_rstn,
    input  wire logic [31:0] i_word,
    input  wire logic        i_valid,
    output logic             o_ready
);
    logic [3:0]  cnt_q;
    logic [31:0] got[$];
    // Stalls eight cycles in sixteen so the two-entry buffer fills and refuses
    assign o_ready = ~cnt_q[3];
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) cnt_q <= 4'h0;
        else begin
            cnt_q <= cnt_q + 4'h1;
            if (i_valid && o_ready) got.push_back(i_word);
        end
    end
endmodule : ioff_sink
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the overlay, format and filter core
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, s); end end
module tb;
    import ioff_pkg::*;
    logic i_mclk = 0, i_rstn = 0, go = 0, pv = 0, pl = 0, oe = 0;
    logic sv = 0, sl = 0, rv = 0, rl = 0, cw = 0;
    ioff_op_t     op  = IOFF_OP_FORMAT;
    ioff_layout_t lay = IOFF_LAY_422_COSITED;
    ioff_ovfmt_t  ovf = IOFF_OV_RGB_888_WITH_BLEND_BYTE;
    ioff_outfmt_t of  = IOFF_OUT_RGB_8BIT_RED2_GREEN3_BLUE3;
    logic [7:0]  ahi = 8'h80, alo = 8'h00, c0 = 0, c1 = 0, c2 = 0, smp = 0, lv = 0;
    logic [31:0] ov = 0, msk = '1;
    logic [4:0]  rc = 0, rp = 0, cph = 0;
    logic [2:0]  ctap = 0;
    logic [9:0]  cd = 0;
    wire logic   pr, qr, wv, wr, cs;
    wire logic [31:0] w;
    wire logic [15:0] yi, ci;
    wire logic [3:0]  li;
    int fail_count = 0, cmp_count = 0;
    logic [7:0] eb[$];
    // Coefficients are 10-bit signed, so every tap stays inside -512..511
    int cf[4][5] = '{'{256, 0, 0, 0, 0}, '{0, 0, 0, 0, 256}, '{128, 0, 0, 0, 128},
                     '{0, -128, 384, 0, 0}};
    always #50 i_mclk = ~i_mclk;
    ioff_core #(.LINE_DEPTH(16)) ioff_core_i (.i_mclk, .i_rstn, .i_job_start(go), .i_op(op),
        .i_layout(lay), .i_ovl_fmt(ovf), .i_out_fmt(of), .i_alpha_hi(ahi), .i_alpha_lo(alo),
        .i_pix_valid(pv), .o_pix_ready(pr), .i_pix_last(pl), .i_img_c0(c0), .i_img_c1(c1),
        .i_img_c2(c2), .i_ovl_word(ov), .i_ovl_en(oe), .o_y_idx(yi), .o_c_idx(ci), .o_c_sited(cs),
        .i_smp_valid(sv), .i_smp_last(sl), .i_smp(smp), .i_req_valid(rv), .o_req_ready(qr),
        .i_req_last(rl), .i_req_center(rc), .i_req_phase(rp), .i_coef_we(cw), .i_coef_phase(cph),
        .i_coef_tap(ctap), .i_coef_data(cd), .o_last_idx(li), .o_word(w), .o_word_valid(wv),
        .i_word_ready(wr));
    ioff_sink ioff_sink_i (.i_mclk, .i_rstn, .i_word(w), .i_valid(wv), .o_ready(wr));
    // ----------
    // Drivers and expectations
    // ----------
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic hs(input bit q);
        logic r;
        for (int n = 0; n < 500; n++) begin
            @(negedge i_mclk) r = q ? qr : pr;
            @(posedge i_mclk) #1;
            if (r) return;
        end
        fail_count++;
        report_and_stop();
    endtask : hs
    task automatic job(input int o, f, vf, l);
        op = ioff_op_t'(o); of = ioff_outfmt_t'(f);
        ovf = ioff_ovfmt_t'(vf); lay = ioff_layout_t'(l);
        go = 1;
        @(posedge i_mclk) #1 go = 0;
    endtask : job
    task automatic pix(input logic [7:0] a, b, c, input logic [31:0] o, input logic l);
        pv = 1; c0 = a; c1 = b; c2 = c; ov = o; pl = l;
        hs(0);
    endtask : pix
    task automatic push(input int f, input logic [7:0] r, g, b, a, input bit odd);
        case (f)
            0: eb.push_back({r[7:6], g[7:5], b[7:5]});
            1: eb.push_back({r[7:5], g[7:5], b[7:6]});
            2: begin eb.push_back({g[5:3], b[7:3]}); eb.push_back({1'b0, r[7:3], g[7:6]}); end
            3: begin eb.push_back({g[4:2], b[7:3]}); eb.push_back({r[7:3], g[7:5]}); end
            4: begin eb.push_back(b); eb.push_back(g); eb.push_back(r); eb.push_back(a); end
            5: begin eb.push_back(b); eb.push_back(g); eb.push_back(r); end
            default: begin eb.push_back(odd ? lv : g); eb.push_back(r); lv = odd ? lv : b; end
        endcase
    endtask : push
    task automatic check_words;
        int n;
        logic [31:0] e;
        pv = 0; rv = 0;
        while (eb.size() % 4 != 0) eb.push_back(8'h00);
        for (n = 0; n < 3000 && ioff_sink_i.got.size() < eb.size() / 4; n++) @(posedge i_mclk);
        if (n == 3000) begin fail_count++; report_and_stop(); end
        #1;
        while (eb.size() > 0) begin
            e = {eb[3], eb[2], eb[1], eb[0]};
            repeat (4) void'(eb.pop_front());
            `CHK("word", e & msk, ioff_sink_i.got.pop_front() & msk)
        end
    endtask : check_words
    function automatic logic [7:0] bl(int i, o, c);
        int a;
        a = c > 128 ? 128 : c;
        return 8'((i * (128 - a) + o * a + 64) >> 7);
    endfunction : bl
    int codes[7] = '{0, 32, 64, 96, 48, 128, 255};
    initial begin
        logic [7:0] r, g, b;
        int s, x, y;
        repeat (2) @(posedge i_mclk);
        #1 i_rstn = 1;
        @(posedge i_mclk) #1;
        for (int f = 0; f < 7; f++) begin
            job(0, f, 0, f % 4);
            msk = f == 2 ? 32'h7fff7fff : '1;
            for (int i = 0; i < 4; i++) begin
                r = 8'h35 + 8'(64 * i); g = 8'hc6 - 8'(33 * i); b = 8'h5a + 8'(51 * i);
                pix(r, g, b, 0, i == 3);
                push(f, r, g, b, 8'h00, i[0]);
            end
            check_words();
        end
        msk = '1;
        job(0, 4, 0, 0);
        oe = 1;
        foreach (codes[i]) begin
            pix(8'h10, 8'h80, 8'hf0, {8'(codes[i]), 24'hf00080}, i == 6);
            push(4, bl(16, 240, codes[i]), bl(128, 0, codes[i]), bl(240, 128, codes[i]),
                 8'(codes[i]), 0);
        end
        check_words();
        job(0, 3, 1, 0);
        for (int i = 0; i < 2; i++) pix(8'h00, 8'hff, 8'h00, 32'h7c1ffc1f, i == 1);
        eb = '{8'h1f, 8'hf8, 8'he0, 8'h07};
        check_words();
        job(0, 6, 2, 0);
        pix(8'h90, 8'h00, 8'h00, 32'hc0aa3055, 0);
        pix(8'ha0, 8'h00, 8'h00, 32'hc0aa3055, 1);
        // Pixel 0 takes the overlay (alpha bit 1), pixel 1 the image; V rides with pixel 0
        eb = '{8'h54, 8'h30, 8'haa, 8'ha0};
        check_words();
        msk = '1;
        oe = 0;
        for (int o = 1; o < 3; o++) begin
            job(o, 0, 0, 0);
            for (int p = 0; p < 20; p++) begin
                cw = 1; cph = 5'(p / 5); ctap = 3'(p % 5); cd = 10'(cf[p / 5][p % 5]);
                @(posedge i_mclk) #1;
            end
            cw = 0;
            for (int i = 0; i < 10; i++) begin
                sv = 1; smp = 8'(20 * i + 7); sl = i == 9;
                @(posedge i_mclk) #1;
            end
            sv = 0; sl = 0;
            `CHK("last index", 4'h9, li)
            for (int c = 0; c < 11; c++) begin
                if (c < 10) begin
                    s = 0;
                    for (int k = 0; k < 5; k++) begin
                        x = c + k - 2;
                        x = x < 0 ? -x : (x > 9 ? 18 - x : x);
                        s += cf[c % 4][k] * (20 * x + 7);
                    end
                    y = (s + 128) >>> 8;
                    y = y < 0 ? 0 : (y > 255 ? 255 : y);
                end
                eb.push_back(8'(y));
                rv = 1; rc = 5'(c); rp = 5'(c % 4); rl = c == 10;
                hs(1);
            end
            check_words();
        end
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
